//--- dv/baseline_core_branch_move_logic_ops_test.sv
`timescale 1ns/1ps
`default_nettype none
module baseline_core_branch_move_logic_ops_test;
  import bcx_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [INSTR_W-1:0] progData = 12'h000;
  logic [PC_W-1:0]    stackTop = 11'h000;
  logic [PC_W-1:0]    progAddr;
  logic [DATA_W-1:0]  accOut;
  logic [DATA_W-1:0]  statusOut;
  logic [DATA_W-1:0]  configOut;
  logic               stackPop;
  logic               retired;
  logic               badOp;
  logic [PC_W-1:0]    pcSave;
  int                 fails = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  bcx_core bcx_core_i (.clk(clk), .rst(rst), .progData(progData), .stackTop(stackTop),
    .progAddr(progAddr), .accOut(accOut), .statusOut(statusOut), .configOut(configOut),
    .stackPop(stackPop), .retired(retired), .badOp(badOp));
  // ----
  // shared tasks
  // ----
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // drive at one edge, executed at the next; nxt waits for the edge after
  task automatic step(input logic [INSTR_W-1:0] w, input logic [INSTR_W-1:0] nxt = 12'h000);
    @(posedge clk);
    progData <= w;
    @(posedge clk);
    progData <= nxt;
    #1;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    chk(progAddr, 11'h000);
    chk(accOut, 8'h00);
    chk(configOut, 8'hff);
    chk(statusOut, 8'h00);
  endtask
  task automatic t_literal();
    step(12'hc00);
    chk(statusOut, 8'h00);
    step(12'hd00);
    chk(statusOut, 8'h04);
    step(12'hca5);
    chk(accOut, 8'ha5);
    chk(statusOut, 8'h04);
    step(12'hd5a);
    chk(accOut, 8'hff);
    chk(statusOut, 8'h00);
  endtask
  task automatic t_file();
    step(12'h027);
    chk(statusOut, 8'h00);
    step(12'hc00);
    step(12'h029);
    step(12'h207);
    chk(accOut, 8'hff);
    step(12'hc11);
    step(12'h229);
    chk(accOut, 8'h11);
    chk(statusOut, 8'h04);
    step(12'h129);
    chk(statusOut, 8'h00);
    step(12'hc00);
    step(12'h209);
    chk(accOut, 8'h11);
    step(12'hd00);
    step(12'h109);
    chk(accOut, 8'h11);
    chk(statusOut, 8'h00);
  endtask
  task automatic t_config();
    step(12'hc3c);
    step(12'h002);
    chk(configOut, 8'h3c);
    chk(statusOut, 8'h00);
  endtask
  task automatic t_jump();
    step(12'hc40);
    step(12'h023);
    step(12'hbff, 12'hd0f);
    chk(progAddr, 11'h5ff);
    chk(retired, 1'b0);
    @(posedge clk);
    progData <= 12'h000;
    #1;
    chk(retired, 1'b1);
    chk(accOut, 8'h40);
    chk(statusOut, 8'h40);
  endtask
  task automatic t_return();
    @(posedge clk);
    stackTop <= 11'h2a5;
    step(12'h800, 12'hd0f);
    chk(accOut, 8'h00);
    chk(progAddr, 11'h2a5);
    chk(stackPop, 1'b1);
    chk(statusOut, 8'h40);
    chk(retired, 1'b0);
    @(posedge clk);
    progData <= 12'h000;
    #1;
    chk(retired, 1'b1);
    chk(accOut, 8'h00);
    chk(stackPop, 1'b0);
  endtask
  task automatic t_idle();
    pcSave = progAddr;
    step(12'h000);
    chk(progAddr, pcSave + 11'h002);
    chk(accOut, 8'h00);
    chk(statusOut, 8'h40);
    chk(configOut, 8'h3c);
    chk(retired, 1'b1);
    chk(badOp, 1'b0);
    step(12'hfff);
    chk(badOp, 1'b1);
    chk(accOut, 8'h00);
    chk(statusOut, 8'h40);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_literal();
    t_file();
    t_config();
    t_jump();
    t_return();
    t_idle();
    results();
  end
endmodule // baseline_core_branch_move_logic_ops_test
`default_nettype wire

//--- dv/bcx_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bcx_core_asserts
  import bcx_pkg::*;
(
  input wire logic               clk,       // clock
  input wire logic               rst,       // reset
  input wire logic [INSTR_W-1:0] progData,  // word
  input wire logic [PC_W-1:0]    stackTop,  // return addr
  input wire logic [PC_W-1:0]    progAddr,  // pc
  input wire logic [DATA_W-1:0]  accOut,    // acc
  input wire logic [DATA_W-1:0]  statusOut, // status
  input wire logic [DATA_W-1:0]  configOut, // config
  input wire logic               stackPop,  // pop
  input wire logic               retired    // done
);
  // ----
  // exec phase tracking
  // ----
  logic flushR;
  logic flushNxt;
  logic ex;
  logic jmp;
  logic ret;
  assign ex = !flushR;
  assign jmp = ex && ((progData & MSK_JMP) == OPC_JMP);
  assign ret = ex && ((progData & MSK_LIT) == OPC_RET);
  always_comb begin
    flushNxt = jmp || ret;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) flushR <= 1'b0;
    else flushR <= flushNxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  jump_target_a: assert property (jmp |=>
    progAddr == {$past(statusOut[PAGE_HI:PAGE_LO]), $past(progData[8:0])}) else $error("jump target wrong");
  jump_cycles_a: assert property (jmp |=>
    !retired && $stable(statusOut) ##1 retired && $stable(statusOut)) else $error("jump timing wrong");
  or_imm_a: assert property (ex && (progData & MSK_LIT) == OPC_ORL |=>
    accOut == ($past(accOut) | $past(progData[7:0])) && statusOut[Z_BIT] == (accOut == 8'h00)
    && ((statusOut ^ $past(statusOut)) & 8'hfb) == 8'h00) else $error("or literal wrong");
  load_imm_a: assert property (ex && (progData & MSK_LIT) == OPC_LDL |=>
    accOut == $past(progData[7:0]) && $stable(statusOut)) else $error("load literal wrong");
  config_load_a: assert property (ex && progData == OPC_CFG |=>
    configOut == $past(accOut) && $stable(statusOut)) else $error("config load wrong");
  return_load_a: assert property (ret |=>
    accOut == $past(progData[7:0]) && progAddr == $past(stackTop) && stackPop && $stable(statusOut))
    else $error("return wrong");
  return_cycles_a: assert property (ret |=> !retired ##1 retired) else $error("return timing wrong");
  idle_op_a: assert property (ex && progData == OPC_IDL |=>
    progAddr == $past(progAddr) + 11'h001 && $stable(accOut) && $stable(statusOut) && $stable(configOut)
    && retired) else $error("idle changed state");
  copy_acc_a: assert property (ex && (progData & MSK_FW) == OPC_CPW && progData[4:0] != STATUS_ADDR |=>
    $stable(statusOut) && $stable(accOut)) else $error("copy to file changed flags");
  or_file_flags_a: assert property (ex && (progData & MSK_FD) == OPC_ORF && !progData[DEST_BIT]
    && progData[4:0] != STATUS_ADDR |=> statusOut[Z_BIT] == (accOut == 8'h00)
    && ((statusOut ^ $past(statusOut)) & 8'hfb) == 8'h00) else $error("or file flags wrong");
  copy_file_flags_a: assert property (ex && (progData & MSK_FD) == OPC_CPF && !progData[DEST_BIT]
    && progData[4:0] != STATUS_ADDR |=> statusOut[Z_BIT] == (accOut == 8'h00)
    && ((statusOut ^ $past(statusOut)) & 8'hfb) == 8'h00) else $error("copy file flags wrong");
endmodule // bcx_core_asserts
bind bcx_core bcx_core_asserts bcx_core_asserts_i (.clk(clk), .rst(rst), .progData(progData),
  .stackTop(stackTop), .progAddr(progAddr), .accOut(accOut), .statusOut(statusOut),
  .configOut(configOut), .stackPop(stackPop), .retired(retired));
`default_nettype wire

//--- hdl/bcx_core.sv
`timescale 1ns/1ps
`default_nettype none
module bcx_core
  import bcx_pkg::*;
(
  input  wire logic               clk,        // instruction clock
  input  wire logic               rst,        // async reset, high
  input  wire logic [INSTR_W-1:0] progData,   // word at progAddr
  input  wire logic [PC_W-1:0]    stackTop,   // return address
  output logic [PC_W-1:0]         progAddr,   // program counter
  output logic [DATA_W-1:0]       accOut,     // accumulator
  output logic [DATA_W-1:0]       statusOut,  // status register
  output logic [DATA_W-1:0]       configOut,  // configuration reg
  output logic                    stackPop,   // stack popped
  output logic                    retired,    // instr completed
  output logic                    badOp       // unknown opcode
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  bcx_phase_e        phase_r, phase_nxt;
  logic [PC_W-1:0]   pc_r, pc_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [DATA_W-1:0] status_r, status_nxt;
  logic [DATA_W-1:0] config_r, config_nxt;
  logic              pop_r, pop_nxt;
  logic              retired_r, retired_nxt;
  logic              bad_r, bad_nxt;

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  bcx_op_e            op;
  logic [8:0]         imm9;
  logic [DATA_W-1:0]  imm8;
  logic [FADDR_W-1:0] fAddr;
  logic               dest;

  bcx_decode bcx_decode_i (
    .instr (progData),
    .op    (op),
    .imm9  (imm9),
    .imm8  (imm8),
    .fAddr (fAddr),
    .dest  (dest)
  );

  // ----------------------------------------------------------
  // file registers
  // ----------------------------------------------------------
  bcx_file_if fileIf ();

  bcx_file_store #(
    .DEPTH (FILE_DEPTH)
  ) bcx_file_store_i (
    .clk (clk),
    .rst (rst),
    .fIf (fileIf)
  );

  logic              isStatus;
  logic [DATA_W-1:0] fileVal;
  logic [DATA_W-1:0] result;
  logic              fileWr;
  logic              execute;

  assign execute  = (phase_r == PH_EXEC);
  assign isStatus = (fAddr == STATUS_ADDR);
  assign fileVal  = isStatus ? status_r : fileIf.rdData;

  // ----------------------------------------------------------
  // datapath result and file write
  // ----------------------------------------------------------
  always_comb begin
    result = acc_r;
    fileWr = 1'b0;
    case (op)
      OP_ORL: result = acc_r | imm8;
      OP_ORF: begin
        result = acc_r | fileVal;
        fileWr = dest;
      end
      OP_CPW: begin
        result = acc_r;
        fileWr = 1'b1;
      end
      OP_CPF: begin
        result = fileVal;
        fileWr = dest;
      end
      OP_LDL: result = imm8;
      OP_RET: result = imm8;
      default: result = acc_r;
    endcase
  end

  assign fileIf.addr   = fAddr;
  assign fileIf.wrData = result;
  assign fileIf.wrEn   = execute & fileWr & ~isStatus;

  // ----------------------------------------------------------
  // sequencing and architectural registers
  // ----------------------------------------------------------
  always_comb begin
    phase_nxt   = PH_EXEC;
    pc_nxt      = pc_r;
    acc_nxt     = acc_r;
    status_nxt  = status_r;
    config_nxt  = config_r;
    pop_nxt     = 1'b0;
    retired_nxt = 1'b0;
    bad_nxt     = 1'b0;
    if (execute) begin
      pc_nxt = pc_r + 11'h001;
      retired_nxt = 1'b1;
      // file write to the status address lands in status
      if (fileWr && isStatus) begin
        status_nxt = result;
      end
      case (op)
        OP_JUMP: begin
          pc_nxt[8:0] = imm9;
          pc_nxt[PC_W-1:9] = status_r[PAGE_HI:PAGE_LO];
          phase_nxt = PH_FLUSH;
          retired_nxt = 1'b0;
        end
        OP_ORL: begin
          acc_nxt = result;
          status_nxt[Z_BIT] = bcxIsZero(result);
        end
        OP_ORF: begin
          if (!dest) begin
            acc_nxt = result;
          end
          status_nxt[Z_BIT] = bcxIsZero(result);
        end
        OP_CPW: begin
          acc_nxt = acc_r;
        end
        OP_CPF: begin
          if (!dest) begin
            acc_nxt = result;
          end
          status_nxt[Z_BIT] = bcxIsZero(result);
        end
        OP_LDL: acc_nxt = result;
        OP_CFG: config_nxt = acc_r;
        OP_RET: begin
          acc_nxt = result;
          pc_nxt = stackTop;
          pop_nxt = 1'b1;
          phase_nxt = PH_FLUSH;
          retired_nxt = 1'b0;
        end
        OP_BAD: bad_nxt = 1'b1;
        default: acc_nxt = acc_r;
      endcase
    end else begin
      // flush cycle: fetched word discarded
      retired_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r   <= PH_EXEC;
      pc_r      <= PC_RST;
      acc_r     <= ACC_RST;
      status_r  <= STATUS_RST;
      config_r  <= CONFIG_RST;
      pop_r     <= 1'b0;
      retired_r <= 1'b0;
      bad_r     <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      pc_r      <= pc_nxt;
      acc_r     <= acc_nxt;
      status_r  <= status_nxt;
      config_r  <= config_nxt;
      pop_r     <= pop_nxt;
      retired_r <= retired_nxt;
      bad_r     <= bad_nxt;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign progAddr  = pc_r;
  assign accOut    = acc_r;
  assign statusOut = status_r;
  assign configOut = config_r;
  assign stackPop  = pop_r;
  assign retired   = retired_r;
  assign badOp     = bad_r;
endmodule // bcx_core
`default_nettype wire

//--- hdl/bcx_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bcx_decode
  import bcx_pkg::*;
(
  input  wire logic [INSTR_W-1:0] instr,  // fetched word
  output var bcx_op_e             op,     // decoded operation
  output logic [8:0]              imm9,   // jump target
  output logic [DATA_W-1:0]       imm8,   // literal
  output logic [FADDR_W-1:0]      fAddr,  // file address
  output logic                    dest    // 1: back to file
);
  always_comb begin
    imm9  = instr[8:0];
    imm8  = instr[DATA_W-1:0];
    fAddr = instr[FADDR_W-1:0];
    dest  = instr[DEST_BIT];
    if ((instr & MSK_JMP) == OPC_JMP) op = OP_JUMP;
    else if ((instr & MSK_LIT) == OPC_ORL) op = OP_ORL;
    else if ((instr & MSK_LIT) == OPC_LDL) op = OP_LDL;
    else if ((instr & MSK_LIT) == OPC_RET) op = OP_RET;
    else if ((instr & MSK_FD) == OPC_ORF) op = OP_ORF;
    else if ((instr & MSK_FD) == OPC_CPF) op = OP_CPF;
    else if ((instr & MSK_FW) == OPC_CPW) op = OP_CPW;
    else if (instr == OPC_IDL) op = OP_IDLE;
    else if (instr == OPC_CFG) op = OP_CFG;
    else op = OP_BAD;
  end
endmodule // bcx_decode
`default_nettype wire

//--- hdl/bcx_file_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bcx_file_if;
  import bcx_pkg::*;
  logic [FADDR_W-1:0] addr;
  logic               wrEn;
  logic [DATA_W-1:0]  wrData;
  logic [DATA_W-1:0]  rdData;
  modport core  (output addr, output wrEn, output wrData, input rdData);
  modport store (input addr, input wrEn, input wrData, output rdData);
endinterface
`default_nettype wire

//--- hdl/bcx_file_store.sv
`timescale 1ns/1ps
`default_nettype none
module bcx_file_store
  import bcx_pkg::*;
#(
  parameter int DEPTH = FILE_DEPTH
) (
  input  wire logic clk,   // instruction clock
  input  wire logic rst,   // async reset
  bcx_file_if.store fIf    // core access
);
  logic [DATA_W-1:0] mem_r   [DEPTH];
  logic [DATA_W-1:0] mem_nxt [DEPTH];

  assign fIf.rdData = mem_r[fIf.addr];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (fIf.wrEn) begin
      mem_nxt[fIf.addr] = fIf.wrData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= FILE_RST;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end
endmodule // bcx_file_store
`default_nettype wire

//--- hdl/bcx_pkg.sv
// Summary of operation
// - jump loads nine-bit immediate into program counter bits 8..0
// - jump fills program counter bits 10..9 from status bits 6..5
// - jump takes two instruction cycles and leaves all flags alone
// - or_imm_into_acc ORs accumulator with literal, result to accumulator, Z only
// - or_acc_file ORs accumulator with file register; dest bit picks target
// - or_acc_file updates zero flag only
// - copy_acc_to_file stores accumulator into file register, flags untouched
// - copy_file sends file value to accumulator or back to register
// - copy_file updates zero flag from moved value
// - load_imm_acc puts literal into accumulator, flags untouched
// - configuration load copies accumulator into configuration register, flags untouched
// - return_imm_acc loads literal into accumulator, pc from stack_top
// - return_imm_acc takes two instruction cycles
`default_nettype none
package bcx_pkg;
  localparam int PC_W    = 11;
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 12;
  localparam int FADDR_W = 5;
  localparam int FILE_DEPTH = 32;

  localparam logic [FADDR_W-1:0] STATUS_ADDR = 5'h03;
  localparam int Z_BIT   = 2;
  localparam int PAGE_LO = 5;
  localparam int PAGE_HI = 6;

  localparam logic [PC_W-1:0]    PC_RST     = 11'h000;
  localparam logic [DATA_W-1:0]  ACC_RST    = 8'h00;
  localparam logic [DATA_W-1:0]  STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0]  CONFIG_RST = 8'hff;
  localparam logic [DATA_W-1:0]  FILE_RST   = 8'h00;

  // opcode patterns and masks
  localparam logic [INSTR_W-1:0] MSK_JMP = 12'he00;
  localparam logic [INSTR_W-1:0] OPC_JMP = 12'ha00;
  localparam logic [INSTR_W-1:0] MSK_LIT = 12'hf00;
  localparam logic [INSTR_W-1:0] OPC_ORL = 12'hd00;
  localparam logic [INSTR_W-1:0] OPC_LDL = 12'hc00;
  localparam logic [INSTR_W-1:0] OPC_RET = 12'h800;
  localparam logic [INSTR_W-1:0] MSK_FD  = 12'hfc0;
  localparam logic [INSTR_W-1:0] OPC_ORF = 12'h100;
  localparam logic [INSTR_W-1:0] OPC_CPF = 12'h200;
  localparam logic [INSTR_W-1:0] MSK_FW  = 12'hfe0;
  localparam logic [INSTR_W-1:0] OPC_CPW = 12'h020;
  localparam logic [INSTR_W-1:0] OPC_IDL = 12'h000;
  localparam logic [INSTR_W-1:0] OPC_CFG = 12'h002;
  localparam int DEST_BIT = 5;

  typedef enum logic [3:0] {
    OP_IDLE = 4'h0,
    OP_JUMP = 4'h1,
    OP_ORL  = 4'h2,
    OP_ORF  = 4'h3,
    OP_CPW  = 4'h4,
    OP_CPF  = 4'h5,
    OP_LDL  = 4'h6,
    OP_CFG  = 4'h7,
    OP_RET  = 4'h8,
    OP_BAD  = 4'h9
  } bcx_op_e;

  typedef enum logic [0:0] {
    PH_EXEC  = 1'b0,
    PH_FLUSH = 1'b1
  } bcx_phase_e;

  function automatic logic bcxIsZero(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction
endpackage
`default_nettype wire
